/* File: logic/ajrl_defs.svh */
// Constants of the anti-jerk ramp limiter
`ifndef AJRL_DEFS_SVH
`define AJRL_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AJRL_OFF_METHOD 4'h0
`define AJRL_OFF_T_UP 4'h1
`define AJRL_OFF_T_DOWN 4'h2
`define AJRL_OFF_T_FAST 4'h3
`define AJRL_OFF_T_ABORT 4'h4
`define AJRL_OFF_UP_SHAPE 4'h5
`define AJRL_OFF_DN_SHAPE 4'h6
`define AJRL_OFF_FAST_THR 4'h7
`define AJRL_OFF_ABORT_THR 4'h8
`define AJRL_OFF_T_UP_HS 4'h9
`define AJRL_OFF_T_DOWN_HS 4'ha
`define AJRL_OFF_SPAN 4'hb
`define AJRL_OFF_STATUS 4'hc

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define AJRL_RST_METHOD 2'h0
`define AJRL_RST_T_UP 10'h001
`define AJRL_RST_T_DOWN 10'h15e
`define AJRL_RST_T_FAST 10'h064
`define AJRL_RST_T_ABORT 10'h001
`define AJRL_RST_SHAPE 4'h0
`define AJRL_RST_FAST_THR 11'h3e8
`define AJRL_RST_ABORT_THR 11'h000
`define AJRL_RST_SPAN 10'h1f4
`define AJRL_T_MAX 10'h3e8
`define AJRL_SHAPE_MAX 4'ha
`define AJRL_THR_OFF 11'h3e8
`define AJRL_ABORT_MAX 11'h1f4

// ----------------------------------------
// Flow scale and curve breakpoints
// ----------------------------------------
`define AJRL_FULL_SCALE 24'h0003e8
`define AJRL_FRAC 12
`define AJRL_BP0 11'h032
`define AJRL_BP1 11'h078
`define AJRL_BP2 11'h14d
`define AJRL_RATIO_SH 10

// ----------------------------------------
// Timing
// ----------------------------------------
`define AJRL_CLK_MHZ 125
`define AJRL_TICK_US 1000

`endif

/* File: logic/ajrl_pkg.sv */
// Types of the anti-jerk ramp limiter
package ajrl_pkg;
	typedef logic signed [10:0] ajrl_flow_t;
	typedef enum logic [1:0] {
		AJRL_M_PASS = 2'h0,
		AJRL_M_FIXED = 2'h1,
		AJRL_M_SPEED = 2'h2
	} ajrl_method_t;
	typedef enum logic [1:0] {
		AJRL_ST_IDLE = 2'h0,
		AJRL_ST_RATIO = 2'h1,
		AJRL_ST_STEP = 2'h3,
		AJRL_ST_APPLY = 2'h2
	} ajrl_state_t;
	typedef enum logic [1:0] {
		AJRL_K_UP = 2'h0,
		AJRL_K_SLOW = 2'h1,
		AJRL_K_FAST = 2'h2,
		AJRL_K_ABORT = 2'h3
	} ajrl_kind_t;
endpackage

/* File: logic/ajrl_serial_div.sv */
// Serial restoring divider with registered quotient
`timescale 1ns/100ps
`default_nettype none
module ajrl_serial_div #(
	parameter int NW = 24,
	parameter int DW = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [NW-1:0] num_i,
	input wire logic [DW-1:0] den_i,
	output logic busy_o,
	output logic done_o,
	output logic [NW-1:0] quot_o
);
	logic [DW-1:0] rem;
	logic [DW-1:0] den;
	logic [5:0] cnt;
	wire [DW:0] trial = {rem, quot_o[NW-1]};
	wire fits = trial >= {1'b0, den};
	wire [DW:0] diff = trial - {1'b0, den};

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rem <= '0;
			den <= '0;
			cnt <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			quot_o <= '0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				quot_o <= num_i;
				den <= den_i;
				rem <= '0;
				cnt <= 6'(NW);
				busy_o <= 1'b1;
			end else if (busy_o) begin
				rem <= fits ? diff[DW-1:0] : trial[DW-1:0];
				quot_o <= {quot_o[NW-2:0], fits};
				cnt <= cnt - 6'h01;
				if (cnt == 6'h01) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end
endmodule // ajrl_serial_div
`default_nettype wire

/* File: logic/ajrl_ramp_limiter.sv */
// Anti-jerk ramp limiter for the valve spool flow set-point
//
// Behaviour
// - Method 0 passes request unramped, 1 fixed ramps, 2 speed-dependent ramps.
// - Output follows the request no faster than the active ramp.
// - Ramp-up time zero to full flow, 1..1000 ms, default 1.
// - Slow ramp-down time full to zero, 1..1000 ms, default 350.
// - Ramp-up curve shape 0 linear to 10 most progressive, default 0.
// - Slow ramp-down curve shape 0..10, default 0 linear.
// - Progressive curve is piecewise with breakpoints at 50, 120, 333.
// - Fast ramp-down above threshold; 1000, the default, disables it.
// - Fast time counts for a full excursion; default 100 ms.
// - Reverse request beyond abort threshold aborts a ramp-down; range 0..500.
// - Aborted ramp-down uses abort time, 1..1000 ms, default 1.
// - Abort threshold 1000 disables abort; default 0 aborts on slight reverse.
// - Speed mode interpolates up and slow-down times between zero and span speed, both signs.
`timescale 1ns/100ps
`default_nettype none
`include "ajrl_defs.svh"
module ajrl_ramp_limiter #(
	parameter int TICK_CYCLES = `AJRL_TICK_US * `AJRL_CLK_MHZ
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire ajrl_pkg::ajrl_flow_t requested_flow_i,
	input wire ajrl_pkg::ajrl_flow_t vehicle_speed_i,
	output ajrl_pkg::ajrl_flow_t limited_flow_o,
	output logic abort_active_o
);
	import ajrl_pkg::*;

	localparam int FR = `AJRL_FRAC;
	localparam int TW = $clog2(TICK_CYCLES + 1);

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	ajrl_method_t method;
	logic [9:0] t_up, t_down, t_fast, t_abort, t_up_hs, t_down_hs, speed_span;
	logic [3:0] up_curve_shape, down_curve_shape;
	logic [10:0] fast_zone_threshold, abort_threshold;

	wire [9:0] wr_time = (reg_wdata_i == 16'h0000) ? 10'h001 :
		(reg_wdata_i > 16'(`AJRL_T_MAX)) ? `AJRL_T_MAX : reg_wdata_i[9:0];
	wire [3:0] wr_shape = (reg_wdata_i > 16'(`AJRL_SHAPE_MAX)) ? `AJRL_SHAPE_MAX : reg_wdata_i[3:0];
	wire [10:0] wr_thr = (reg_wdata_i > 16'(`AJRL_THR_OFF)) ? `AJRL_THR_OFF : reg_wdata_i[10:0];
	wire [10:0] wr_abort_thr = (wr_thr == `AJRL_THR_OFF) ? `AJRL_THR_OFF :
		(wr_thr > `AJRL_ABORT_MAX) ? `AJRL_ABORT_MAX : wr_thr;
	wire wr_method_ok = reg_wdata_i <= 16'(AJRL_M_SPEED);

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			method <= ajrl_method_t'(`AJRL_RST_METHOD);
			t_up <= `AJRL_RST_T_UP;
			t_down <= `AJRL_RST_T_DOWN;
			t_fast <= `AJRL_RST_T_FAST;
			t_abort <= `AJRL_RST_T_ABORT;
			t_up_hs <= `AJRL_RST_T_UP;
			t_down_hs <= `AJRL_RST_T_DOWN;
			speed_span <= `AJRL_RST_SPAN;
			up_curve_shape <= `AJRL_RST_SHAPE;
			down_curve_shape <= `AJRL_RST_SHAPE;
			fast_zone_threshold <= `AJRL_RST_FAST_THR;
			abort_threshold <= `AJRL_RST_ABORT_THR;
		end else if (ce_i && reg_wr_i) begin
			unique case (reg_addr_i)
				`AJRL_OFF_METHOD: if (wr_method_ok) method <= ajrl_method_t'(reg_wdata_i[1:0]);
				`AJRL_OFF_T_UP: t_up <= wr_time;
				`AJRL_OFF_T_DOWN: t_down <= wr_time;
				`AJRL_OFF_T_FAST: t_fast <= wr_time;
				`AJRL_OFF_T_ABORT: t_abort <= wr_time;
				`AJRL_OFF_UP_SHAPE: up_curve_shape <= wr_shape;
				`AJRL_OFF_DN_SHAPE: down_curve_shape <= wr_shape;
				`AJRL_OFF_FAST_THR: fast_zone_threshold <= wr_thr;
				`AJRL_OFF_ABORT_THR: abort_threshold <= wr_abort_thr;
				`AJRL_OFF_T_UP_HS: t_up_hs <= wr_time;
				`AJRL_OFF_T_DOWN_HS: t_down_hs <= wr_time;
				`AJRL_OFF_SPAN: speed_span <= wr_time;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [15:0] rd_mux;
	always_comb begin
		unique case (reg_addr_i)
			`AJRL_OFF_METHOD: rd_mux = {14'h0000, method};
			`AJRL_OFF_T_UP: rd_mux = {6'h00, t_up};
			`AJRL_OFF_T_DOWN: rd_mux = {6'h00, t_down};
			`AJRL_OFF_T_FAST: rd_mux = {6'h00, t_fast};
			`AJRL_OFF_T_ABORT: rd_mux = {6'h00, t_abort};
			`AJRL_OFF_UP_SHAPE: rd_mux = {12'h000, up_curve_shape};
			`AJRL_OFF_DN_SHAPE: rd_mux = {12'h000, down_curve_shape};
			`AJRL_OFF_FAST_THR: rd_mux = {5'h00, fast_zone_threshold};
			`AJRL_OFF_ABORT_THR: rd_mux = {5'h00, abort_threshold};
			`AJRL_OFF_T_UP_HS: rd_mux = {6'h00, t_up_hs};
			`AJRL_OFF_T_DOWN_HS: rd_mux = {6'h00, t_down_hs};
			`AJRL_OFF_SPAN: rd_mux = {6'h00, speed_span};
			`AJRL_OFF_STATUS: rd_mux = {abort_active_o, 4'h0, limited_flow_o};
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) reg_rdata_o <= 16'h0000;
		else if (ce_i) reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
	end

	// ----------------------------------------
	// Control tick
	// ----------------------------------------
	logic [TW-1:0] tick_cnt;
	wire tick = tick_cnt == TW'(TICK_CYCLES - 1);
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) tick_cnt <= '0;
		else if (ce_i) tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
	end

	// ----------------------------------------
	// Ramp direction and kind
	// ----------------------------------------
	ajrl_state_t st;
	logic signed [23:0] acc;
	ajrl_flow_t req_q;
	logic [23:0] step_q;

	wire signed [23:0] acc_int = acc >>> FR;
	wire ajrl_flow_t cur_flow = acc_int[10:0];
	wire [10:0] cur_mag = cur_flow[10] ? 11'(-cur_flow) : cur_flow;
	wire [10:0] req_mag = req_q[10] ? 11'(-req_q) : req_q;
	wire opposite = (cur_flow != 0) && (req_q != 0) && (cur_flow[10] != req_q[10]);
	wire rising = !opposite && (req_mag >= cur_mag);
	wire in_fast = cur_mag > fast_zone_threshold;
	wire abort_hit = !rising && opposite && (abort_threshold != `AJRL_THR_OFF) &&
		(req_mag > abort_threshold);
	wire abort_now = abort_active_o || abort_hit;
	wire ajrl_kind_t kind = rising ? AJRL_K_UP : abort_now ? AJRL_K_ABORT :
		in_fast ? AJRL_K_FAST : AJRL_K_SLOW;

	// ----------------------------------------
	// Ramp time, speed interpolation
	// ----------------------------------------
	logic div_busy, div_done;
	logic [23:0] div_quot;
	wire [10:0] spd_mag = vehicle_speed_i[10] ? 11'(-vehicle_speed_i) : vehicle_speed_i;
	wire [10:0] spd_clip = (spd_mag > {1'b0, speed_span}) ? {1'b0, speed_span} : spd_mag;
	wire [23:0] ratio_num = {3'h0, spd_clip, 10'h000};
	wire [9:0] t_lo = (kind == AJRL_K_UP) ? t_up : (kind == AJRL_K_SLOW) ? t_down :
		(kind == AJRL_K_FAST) ? t_fast : t_abort;
	wire [9:0] t_hi = (kind == AJRL_K_UP) ? t_up_hs : (kind == AJRL_K_SLOW) ? t_down_hs : t_lo;
	wire signed [11:0] t_span = $signed({2'b00, t_hi}) - $signed({2'b00, t_lo});
	wire signed [23:0] t_prod = t_span * $signed({1'b0, div_quot[10:0]});
	wire signed [23:0] t_ofs = t_prod >>> `AJRL_RATIO_SH;
	wire [9:0] t_speed = 10'($signed({2'b00, t_lo}) + t_ofs[11:0]);
	wire [9:0] t_act = (method == AJRL_M_SPEED) ? t_speed : t_lo;
	wire [23:0] step_num = (`AJRL_FULL_SCALE << FR) * 24'(`AJRL_TICK_US / 1000);
	wire div_start = (st == AJRL_ST_IDLE && tick && method != AJRL_M_PASS) ||
		(st == AJRL_ST_RATIO && div_done);
	wire [23:0] div_num = (st == AJRL_ST_IDLE) ? ratio_num : step_num;
	wire [15:0] div_den = (st == AJRL_ST_IDLE) ? {6'h00, speed_span} :
		{6'h00, (t_act == 10'h000) ? 10'h001 : t_act};

	ajrl_serial_div #(.NW(24), .DW(16)) u_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.start_i(div_start),
		.num_i(div_num),
		.den_i(div_den),
		.busy_o(div_busy),
		.done_o(div_done),
		.quot_o(div_quot)
	);

	// ----------------------------------------
	// Progressive curve gain
	// ----------------------------------------
	wire [8:0] bp_gain = (cur_mag < `AJRL_BP0) ? 9'h040 : (cur_mag < `AJRL_BP1) ? 9'h080 :
		(cur_mag < `AJRL_BP2) ? 9'h0c0 : 9'h100;
	wire [3:0] shape = (kind == AJRL_K_UP) ? up_curve_shape :
		(kind == AJRL_K_SLOW) ? down_curve_shape : 4'h0;
	wire [15:0] red_prod = 16'(9'h100 - bp_gain) * 16'(shape) * 16'h001a;
	wire [8:0] gain = 9'h100 - 9'(red_prod >> 8);
	wire [32:0] step_prod = {9'h000, step_q} * {24'h000000, gain};
	wire signed [23:0] step_eff = $signed({1'b0, step_prod[30:8]});

	// ----------------------------------------
	// Limited flow update
	// ----------------------------------------
	wire signed [23:0] req_acc = $signed(req_q) <<< FR;
	wire signed [23:0] target = opposite ? 24'sh000000 : req_acc;
	wire signed [23:0] gap = target - acc;
	wire signed [23:0] next_acc_ramp = (gap > step_eff) ? acc + step_eff :
		(gap < -step_eff) ? acc - step_eff : target;
	wire signed [23:0] next_acc_pass = $signed(requested_flow_i) <<< FR;
	wire signed [23:0] next_acc = (method == AJRL_M_PASS) ? next_acc_pass :
		(st == AJRL_ST_APPLY) ? next_acc_ramp : acc;
	wire signed [23:0] next_int = next_acc >>> FR;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			st <= AJRL_ST_IDLE;
			acc <= 24'sh000000;
			req_q <= 11'sh000;
			step_q <= 24'h000000;
			limited_flow_o <= 11'sh000;
			abort_active_o <= 1'b0;
		end else if (ce_i) begin
			acc <= next_acc;
			limited_flow_o <= next_int[10:0];
			if (method == AJRL_M_PASS) begin
				st <= AJRL_ST_IDLE;
				abort_active_o <= 1'b0;
			end else begin
				unique case (st)
					AJRL_ST_IDLE: if (tick) begin
						req_q <= requested_flow_i;
						st <= AJRL_ST_RATIO;
					end
					AJRL_ST_RATIO: if (div_done) begin
						abort_active_o <= abort_now;
						st <= AJRL_ST_STEP;
					end
					AJRL_ST_STEP: if (div_done) begin
						step_q <= div_quot;
						st <= AJRL_ST_APPLY;
					end
					AJRL_ST_APPLY: begin
						if (next_acc == 24'sh000000 || !opposite) abort_active_o <= 1'b0;
						st <= AJRL_ST_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_pass_mode_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(ce_i && method == AJRL_M_PASS) |=> limited_flow_o == $past(requested_flow_i))
		else $error("pass mode output not equal to request");
	a_reset_ramp_times: assert property (@(posedge core_clk_i)
		!rst_n_i |=> t_up == 10'h001 && t_down == 10'h15e && method == AJRL_M_PASS)
		else $error("ramp times not at default after reset");
	a_reset_fast_abort: assert property (@(posedge core_clk_i)
		!rst_n_i |=> fast_zone_threshold == 11'h3e8 && t_fast == 10'h064 && t_abort == 10'h001)
		else $error("fast or abort defaults wrong");
	a_shape_in_range: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		up_curve_shape <= 4'ha && down_curve_shape <= 4'ha)
		else $error("curve shape beyond range");
	a_linear_no_gain: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		shape == 4'h0 |-> gain == 9'h100)
		else $error("linear curve scaled the step");
	a_hold_between_ticks: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(ce_i && method != AJRL_M_PASS && st != AJRL_ST_APPLY && !reg_wr_i)
		|=> $stable(limited_flow_o))
		else $error("output moved outside a tick update");
	a_abort_off_value: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(abort_active_o) |-> $past(abort_threshold) != 11'h3e8 && $past(st) == AJRL_ST_RATIO)
		else $error("abort raised while disabled");
	a_abort_reverse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(abort_active_o) |-> $past(opposite) && $past(req_mag) > $past(abort_threshold))
		else $error("abort without reverse request");
	a_tick_starts_calc: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(ce_i && tick && st == AJRL_ST_IDLE && method != AJRL_M_PASS && !reg_wr_i)
		|=> st == AJRL_ST_RATIO ##1 div_busy)
		else $error("tick did not start the ramp update");
	a_flow_bounded: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(method != AJRL_M_PASS && $past(method) != AJRL_M_PASS && st == AJRL_ST_APPLY &&
		ce_i && !reg_wr_i) |=> (limited_flow_o <= 11'sh3e8 && limited_flow_o >= -11'sh3e8))
		else $error("limited flow beyond full scale");
	a_pass_clears_abort: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(ce_i && method == AJRL_M_PASS) |=> !abort_active_o)
		else $error("abort flag kept in pass mode");
	a_time_in_range: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		t_up != 10'h000 && t_up <= 10'h3e8 && t_down != 10'h000 && t_down <= 10'h3e8)
		else $error("ramp time outside its range");
	a_abort_thr_range: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		abort_threshold <= 11'h1f4 || abort_threshold == 11'h3e8)
		else $error("abort threshold outside its range");
	a_fast_thr_range: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		fast_zone_threshold <= 11'h3e8)
		else $error("fast zone threshold beyond full scale");
	a_abort_time_used: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(st == AJRL_ST_STEP && abort_active_o && !rising && method == AJRL_M_FIXED)
		|-> t_act == t_abort)
		else $error("aborted ramp-down not using abort time");
	a_ce_freezes: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!ce_i |=> $stable(limited_flow_o) && $stable(abort_active_o) && $stable(reg_rdata_o))
		else $error("state moved while clock enable low");
endmodule // ajrl_ramp_limiter
`default_nettype wire

/* File: bench/ajrl_steer_model.sv */
// Request source and set-point step monitor for the ramp limiter
`timescale 1ns/100ps
`default_nettype none
module ajrl_steer_model (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	input wire ajrl_pkg::ajrl_flow_t target_i,
	input wire ajrl_pkg::ajrl_flow_t limited_flow_i,
	output ajrl_pkg::ajrl_flow_t requested_flow_o,
	output logic [11:0] max_step_o
);
	import ajrl_pkg::*;
	ajrl_flow_t prev;
	logic [11:0] delta;
	logic [11:0] mag;
	// Widened so that a full swing cannot wrap
	assign delta = {limited_flow_i[10], limited_flow_i} - {prev[10], prev};
	assign mag = delta[11] ? -delta : delta;
	always_ff @(posedge core_clk_i) begin
		prev <= limited_flow_i;
		requested_flow_o <= rst_n_i ? target_i : 11'h000;
		if (!rst_n_i || clr_i) begin
			max_step_o <= 12'h000;
		end else if (mag > max_step_o) begin
			max_step_o <= mag;
		end
	end
endmodule // ajrl_steer_model
`default_nettype wire

/* File: bench/antijerk_ramp_limiter_test.sv */
// Self-checking bench of the ramp limiter
`timescale 1ns/100ps
`default_nettype none
module antijerk_ramp_limiter_test;
	import ajrl_pkg::*;
	localparam int TICK = 200;
	localparam logic [15:0] DFLT [12] = '{16'h0000, 16'h0001, 16'h015e, 16'h0064,
		16'h0001, 16'h0000, 16'h0000, 16'h03e8, 16'h0000, 16'h0001, 16'h015e, 16'h01f4};
	logic clk, rst_n, ce, wr_s, rd_s, clr, abort;
	logic [3:0] addr;
	logic [15:0] wdata, rdata;
	logic [11:0] max_step;
	ajrl_flow_t target, req, speed, flow;
	int miscompares = 0;
	int n_compared = 0;

	ajrl_ramp_limiter #(.TICK_CYCLES(TICK)) u_ajrl_ramp_limiter (.core_clk_i(clk),
		.rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .requested_flow_i(req),
		.vehicle_speed_i(speed), .limited_flow_o(flow), .abort_active_o(abort));
	ajrl_steer_model u_ajrl_steer_model (.core_clk_i(clk), .rst_n_i(rst_n), .clr_i(clr),
		.target_i(target), .limited_flow_i(flow), .requested_flow_o(req),
		.max_step_o(max_step));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		check(rdata, e);
	endtask
	task automatic ask(input ajrl_flow_t v);
		@(posedge clk);
		target <= v;
	endtask
	task automatic preset(input ajrl_flow_t v);
		wr(4'h0, 16'h0000);
		ask(v);
		repeat (3) @(posedge clk);
	endtask
	// Next set-point update must land on the expected value
	task automatic step_to(input ajrl_flow_t e);
		ajrl_flow_t old;
		int n;
		old = flow;
		n = 0;
		while (flow === old && n < 3 * TICK) begin
			@(negedge clk);
			n++;
		end
		if (n >= 3 * TICK) begin
			miscompares++;
			$display("wrong value at %0t: no set-point update", $time);
			finish_test();
		end
		check(16'(flow), 16'(e));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_defaults();
		for (int i = 0; i < 12; i++) begin
			rd_chk(4'(i), DFLT[i]);
		end
		@(posedge clk);
		#1;
		check(rdata, 16'h0000);
		rd_chk(4'hd, 16'h0000);
		$display("test defaults done");
	endtask
	task automatic t_clamp();
		wr(4'h1, 16'h0000);
		rd_chk(4'h1, 16'h0001);
		wr(4'h2, 16'h07d0);
		rd_chk(4'h2, 16'h03e8);
		wr(4'h5, 16'h000f);
		rd_chk(4'h5, 16'h000a);
		wr(4'h8, 16'h02bc);
		rd_chk(4'h8, 16'h01f4);
		wr(4'h8, 16'h03e8);
		rd_chk(4'h8, 16'h03e8);
		wr(4'h0, 16'h0003);
		rd_chk(4'h0, 16'h0000);
		wr(4'h4, 16'h0400);
		rd_chk(4'h4, 16'h03e8);
		@(posedge clk);
		ce <= 1'b0;
		wr(4'h1, 16'h0005);
		ce <= 1'b1;
		rd_chk(4'h1, 16'h0001);
		wr(4'h5, 16'h0000);
		wr(4'h8, 16'h0000);
		preset(11'h544);
		check(16'(flow), 16'hfd44);
		$display("test clamp and pass done");
	endtask
	task automatic t_ramp_up();
		preset(11'h000);
		wr(4'h1, 16'h000a);
		wr(4'h0, 16'h0001);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		ask(11'h1f4);
		for (int i = 1; i <= 5; i++) begin
			step_to(11'(100 * i));
		end
		check(16'(max_step), 16'h0064);
		$display("test ramp up done");
	endtask
	task automatic t_abort();
		preset(11'h1f4);
		wr(4'h2, 16'h0014);
		wr(4'h4, 16'h000a);
		wr(4'h0, 16'h0001);
		ask(11'h000);
		step_to(11'h1c2);
		ask(11'h6d4);
		step_to(11'h15e);
		check({15'h0, abort}, 16'h0001);
		rd_chk(4'hc, 16'h815e);
		for (int i = 2; i >= 0; i--) begin
			step_to(11'(50 + 100 * i));
		end
		step_to(11'h000);
		repeat (3) @(negedge clk);
		check({15'h0, abort}, 16'h0000);
		step_to(11'h79c);
		preset(11'h1f4);
		wr(4'h8, 16'h03e8);
		wr(4'h0, 16'h0001);
		ask(11'h6d4);
		step_to(11'h1c2);
		check({15'h0, abort}, 16'h0000);
		wr(4'h8, 16'h0000);
		$display("test abort done");
	endtask
	task automatic t_fast();
		preset(11'h3e8);
		wr(4'h2, 16'h03e8);
		wr(4'h3, 16'h000a);
		wr(4'h7, 16'h0320);
		wr(4'h0, 16'h0001);
		ask(11'h000);
		step_to(11'h384);
		step_to(11'h320);
		step_to(11'h31f);
		wr(4'h7, 16'h03e8);
		$display("test fast zone done");
	endtask
	task automatic t_shape();
		preset(11'h000);
		wr(4'h1, 16'h000a);
		wr(4'h5, 16'h000a);
		wr(4'h0, 16'h0001);
		ask(11'h1f4);
		step_to(11'h017);
		step_to(11'h02f);
		step_to(11'h047);
		step_to(11'h078);
		step_to(11'h0c3);
		wr(4'h5, 16'h0000);
		wr(4'h6, 16'h000a);
		wr(4'h2, 16'h000a);
		ask(11'h000);
		step_to(11'h078);
		step_to(11'h02e);
		wr(4'h6, 16'h0000);
		$display("test curve shape done");
	endtask
	task automatic t_speed();
		preset(11'h000);
		wr(4'h1, 16'h0064);
		wr(4'h9, 16'h000a);
		wr(4'h0, 16'h0002);
		ask(11'h1f4);
		step_to(11'h00a);
		@(posedge clk);
		speed <= 11'h60c;
		step_to(11'h06e);
		$display("test speed ramps done");
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		clr = 1'b0;
		ce = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		target = 11'h000;
		speed = 11'h000;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_defaults();
		t_clamp();
		t_ramp_up();
		t_abort();
		t_fast();
		t_shape();
		t_speed();
		finish_test();
	end
endmodule // antijerk_ramp_limiter_test
`default_nettype wire
